/* common/pcc_defines.svh */
// constants for the strap-configured clock mode controller
// Contract
// - provide a multiplier controller, dividers /2 /4 /6 /8 and a reset controller
// - source clock comes from the reference input; mode from the two sampled select pins
// - CPU clock is either the multiplied clock or the bypassed reference clock
// - 00 bypass, 01 times six, 10 times twelve, 11 reserved; board straps valid codes
// - undriven select pins are pulled low, so the default is bypass
// - multiply modes wait the worst-case lock interval; bypass needs no wait
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PCC_CLK_PERIOD_NS   50
`define PCC_LOCK_TYP_NS     75000
// worst case is typical plus 150 percent
`define PCC_LOCK_WORST_PCT  250
// least time, so round up to whole cycles
`define PCC_LOCK_CYCLES     ((`PCC_LOCK_TYP_NS * `PCC_LOCK_WORST_PCT + 100 * `PCC_CLK_PERIOD_NS - 1) / (100 * `PCC_CLK_PERIOD_NS))

// ------------------------------------------------------------
// strap synchroniser and multiply factors
// ------------------------------------------------------------
`define PCC_SYNC_STAGES     2'h3
`define PCC_MULT_X1         4'h1
`define PCC_MULT_X6         4'h6
`define PCC_MULT_X12        4'hC

// ------------------------------------------------------------
// divide ratios of the derived clocks
// ------------------------------------------------------------
`define PCC_DIV_HALF        2
`define PCC_DIV_QUARTER     4
`define PCC_DIV_SIXTH       6
`define PCC_DIV_EIGHTH      8
`define PCC_NUM_DIVIDERS    4

`endif

/* common/pcc_pkg.sv */
// types shared by the clock mode controller
package pcc_pkg;

   // ------------------------------------------------------------
   // strap pin pair
   // ------------------------------------------------------------
   typedef struct packed {
      logic hi;
      logic lo;
   } pcc_strap_s;

   // ------------------------------------------------------------
   // ratio encodings and controller states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PCC_RATIO_BYPASS = 2'b00,
      PCC_RATIO_X6     = 2'b01,
      PCC_RATIO_X12    = 2'b10,
      PCC_RATIO_RSVD   = 2'b11
   } pcc_ratio_e;

   typedef enum logic [1:0] {
      PCC_ST_SAMPLE = 2'b00,
      PCC_ST_LOCK   = 2'b01,
      PCC_ST_RUN    = 2'b10
   } pcc_state_e;

endpackage

/* hw/pcc_clock_divider.sv */
// even divide-by-N clock generator with a run gate
`timescale 1ns/1ps
module pcc_clock_divider
   import pcc_pkg::*;
#(
   parameter int DIV = 2
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic run,
   output logic      clk_out
);

   localparam int HALF = DIV / 2;
   localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;

   logic [CW-1:0] cnt;

   // ------------------------------------------------------------
   // half-period counter
   // ------------------------------------------------------------
   // held at zero while stopped so every start is phase aligned
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt     <= '0;
         clk_out <= 1'b0;
      end else if (!run) begin
         cnt     <= '0;
         clk_out <= 1'b0;
      end else if (cnt == CW'(HALF - 1)) begin
         cnt     <= '0;
         clk_out <= ~clk_out;
      end else begin
         cnt     <= cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_half_period;
      @(posedge clk) disable iff (!arst_n)
      $changed(clk_out) && $past(run) |-> $past(cnt) == CW'(HALF - 1);
   endproperty
   a_half_period: assert property (p_half_period) else $error("divider edge off its half period");

   property p_stopped_low;
      @(posedge clk) disable iff (!arst_n)
      !run |=> !clk_out;
   endproperty
   a_stopped_low: assert property (p_stopped_low) else $error("divider output high while stopped");

endmodule

/* hw/pcc_clock_ctrl.sv */
// strap-configured clock mode controller with lock wait, reset release and dividers
`timescale 1ns/1ps
`include "pcc_defines.svh"
module pcc_clock_ctrl
   import pcc_pkg::*;
#(
   parameter int LOCK_CYCLES = `PCC_LOCK_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire pcc_strap_s pll_ratio_select,
   input  wire pcc_strap_s pll_ratio_select_driven,
   output pcc_ratio_e      pll_ratio,
   output logic [3:0]      pll_mult_factor,
   output logic            pll_enable,
   output logic            pll_bypass,
   output logic            strap_reserved,
   output logic            cpu_clock_valid,
   output logic            core_reset_n,
   output logic            half_rate_clock_out,
   output logic            quarter_rate_clock_out,
   output logic            sixth_rate_clock_out,
   output logic            eighth_rate_clock_out
);

   localparam int LW = $clog2(LOCK_CYCLES + 1);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic pcc_ratio_e decode_ratio(input pcc_strap_s s);
      decode_ratio = pcc_ratio_e'({s.hi, s.lo});
   endfunction

   function automatic logic [3:0] mult_of(input pcc_ratio_e r);
      case (r)
         PCC_RATIO_X6:  mult_of = `PCC_MULT_X6;
         PCC_RATIO_X12: mult_of = `PCC_MULT_X12;
         default:       mult_of = `PCC_MULT_X1;
      endcase
   endfunction

   function automatic logic is_multiply(input pcc_ratio_e r);
      is_multiply = (r == PCC_RATIO_X6) || (r == PCC_RATIO_X12);
   endfunction

   // ------------------------------------------------------------
   // pad level and strap synchroniser
   // ------------------------------------------------------------
   pcc_strap_s pad_level;
   pcc_strap_s sync1;
   pcc_strap_s sync2;
   pcc_strap_s sync3;
   logic [1:0] fill_cnt;
   logic       strap_stable;

   // undriven pins read low through the pull-downs
   assign pad_level = pll_ratio_select & pll_ratio_select_driven;

   // straps are asynchronous to clk, so three stages
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= pad_level;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // pipeline must be full of real samples before latching
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fill_cnt <= 2'h0;
      end else if (fill_cnt != `PCC_SYNC_STAGES) begin
         fill_cnt <= fill_cnt + 2'h1;
      end
   end

   assign strap_stable = (fill_cnt == `PCC_SYNC_STAGES) && (sync2 == sync3);

   // ------------------------------------------------------------
   // mode state machine
   // ------------------------------------------------------------
   pcc_state_e state;
   pcc_state_e next_state;
   pcc_ratio_e strap_ratio;
   logic [LW-1:0] lock_cnt;

   assign strap_ratio = decode_ratio(sync3);

   always_comb begin
      next_state = state;
      case (state)
         PCC_ST_SAMPLE: begin
            if (strap_stable) begin
               // bypass and reserved run at once, no lock wait
               next_state = is_multiply(strap_ratio) ? PCC_ST_LOCK : PCC_ST_RUN;
            end
         end
         PCC_ST_LOCK: begin
            if (lock_cnt == LW'(LOCK_CYCLES - 1)) begin
               next_state = PCC_ST_RUN;
            end
         end
         PCC_ST_RUN: begin
            next_state = PCC_ST_RUN;
         end
         default: begin
            next_state = PCC_ST_SAMPLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= PCC_ST_SAMPLE;
      end else begin
         state <= next_state;
      end
   end

   // lock interval counter, worst case not typical
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_cnt <= '0;
      end else if (state == PCC_ST_LOCK) begin
         lock_cnt <= lock_cnt + 1'b1;
      end else begin
         lock_cnt <= '0;
      end
   end

   // ------------------------------------------------------------
   // latched mode and multiplier controls
   // ------------------------------------------------------------
   // captured once after reset release; later strap changes are ignored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pll_ratio       <= PCC_RATIO_BYPASS;
         pll_mult_factor <= `PCC_MULT_X1;
         pll_enable      <= 1'b0;
         pll_bypass      <= 1'b1;
         strap_reserved  <= 1'b0;
      end else if (state == PCC_ST_SAMPLE && strap_stable) begin
         pll_ratio       <= strap_ratio;
         pll_mult_factor <= mult_of(strap_ratio);
         pll_enable      <= is_multiply(strap_ratio);
         pll_bypass      <= !is_multiply(strap_ratio);
         // reserved code falls back to bypass and is flagged
         strap_reserved  <= (strap_ratio == PCC_RATIO_RSVD);
      end
   end

   // ------------------------------------------------------------
   // clock valid and reset controller
   // ------------------------------------------------------------
   // core reset trails clock valid by one cycle so dividers start first
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_clock_valid <= 1'b0;
         core_reset_n    <= 1'b0;
      end else begin
         cpu_clock_valid <= (next_state == PCC_ST_RUN);
         core_reset_n    <= cpu_clock_valid;
      end
   end

   // ------------------------------------------------------------
   // derived clock dividers
   // ------------------------------------------------------------
   localparam int DIVS [`PCC_NUM_DIVIDERS] = '{`PCC_DIV_HALF, `PCC_DIV_QUARTER, `PCC_DIV_SIXTH, `PCC_DIV_EIGHTH};
   logic [`PCC_NUM_DIVIDERS-1:0] div_clk;

   // dividers run only on a usable CPU clock, in every mode
   for (genvar g = 0; g < `PCC_NUM_DIVIDERS; g++) begin : g_div
      pcc_clock_divider #(
         .DIV     (DIVS[g])
      ) u_div (
         .clk     (clk),
         .arst_n  (arst_n),
         .run     (cpu_clock_valid),
         .clk_out (div_clk[g])
      );
   end

   assign half_rate_clock_out    = div_clk[0];
   assign quarter_rate_clock_out = div_clk[1];
   assign sixth_rate_clock_out   = div_clk[2];
   assign eighth_rate_clock_out  = div_clk[3];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_mode_frozen;
      @(posedge clk) disable iff (!arst_n)
      state != PCC_ST_SAMPLE && $past(state) != PCC_ST_SAMPLE |-> $stable(pll_ratio);
   endproperty
   a_mode_frozen: assert property (p_mode_frozen) else $error("latched ratio changed after capture");

   property p_path_select;
      @(posedge clk) disable iff (!arst_n)
      state != PCC_ST_SAMPLE |-> pll_bypass == !is_multiply(pll_ratio) && pll_enable == !pll_bypass;
   endproperty
   a_path_select: assert property (p_path_select) else $error("multiplier path disagrees with ratio");

   property p_factor;
      @(posedge clk) disable iff (!arst_n)
      state == PCC_ST_SAMPLE && strap_stable |=> pll_mult_factor == mult_of($past(strap_ratio))
         && strap_reserved == ($past(strap_ratio) == PCC_RATIO_RSVD);
   endproperty
   a_factor: assert property (p_factor) else $error("wrong multiply factor for strap code");

   property p_pulldown;
      @(posedge clk) disable iff (!arst_n)
      pll_ratio_select_driven == 2'b00 [*4] |-> strap_ratio == PCC_RATIO_BYPASS;
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("undriven straps did not read bypass");

   property p_lock_wait;
      @(posedge clk) disable iff (!arst_n)
      $rose(cpu_clock_valid) && pll_enable |-> $past(lock_cnt) == LW'(LOCK_CYCLES - 1);
   endproperty
   a_lock_wait: assert property (p_lock_wait) else $error("clock valid before lock interval");

   property p_bypass_fast;
      @(posedge clk) disable iff (!arst_n)
      state == PCC_ST_SAMPLE && strap_stable && !is_multiply(strap_ratio) |=> cpu_clock_valid ##1 core_reset_n;
   endproperty
   a_bypass_fast: assert property (p_bypass_fast) else $error("bypass did not go valid at once");

   property p_periph_gated;
      @(posedge clk) disable iff (!arst_n)
      !cpu_clock_valid |=> !quarter_rate_clock_out && !sixth_rate_clock_out;
   endproperty
   a_periph_gated: assert property (p_periph_gated) else $error("peripheral clock ran without CPU clock");

   property p_quarter_first_edge;
      @(posedge clk) disable iff (!arst_n)
      $rose(cpu_clock_valid) |-> !quarter_rate_clock_out ##2 quarter_rate_clock_out ##1 sixth_rate_clock_out;
   endproperty
   a_quarter_first_edge: assert property (p_quarter_first_edge) else $error("divided clocks started late");

endmodule

/* dv/pcc_strap_board.sv */
// board-side strap model: drivers or pull-ups fitted on the two ratio select pins
`timescale 1ns/1ps
module pcc_strap_board
   import pcc_pkg::*;
(
   input  wire logic [1:0] code,
   input  wire logic [1:0] fitted,
   output pcc_strap_s      pins,
   output pcc_strap_s      driven
);
   // ------------------------------------------------------------
   // pin levels
   // ------------------------------------------------------------
   // an unfitted pin still shows the board level here, so the chip's own pull-down masking is what gets tested
   assign driven = pcc_strap_s'(fitted);
   assign pins   = pcc_strap_s'(code);
endmodule

/* dv/pcc_clock_ctrl_test.sv */
// self-checking bench for the strap-configured clock mode controller
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("wrong value %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module pcc_clock_ctrl_test
   import pcc_pkg::*;
;
   localparam int LOCK = 8; // short lock wait keeps the run brief

   // start values given at declaration so no initial block races the first scenario
   logic       clk             = 1'b0;
   logic       arst_n          = 1'b0;
   logic [1:0] code            = 2'b00;
   logic [1:0] fitted          = 2'b00;
   pcc_strap_s pins;
   pcc_strap_s driven;
   pcc_ratio_e pll_ratio;
   logic [3:0] pll_mult_factor;
   logic       pll_enable;
   logic       pll_bypass;
   logic       strap_reserved;
   logic       cpu_clock_valid;
   logic       core_reset_n;
   logic [3:0] divs;
   int         bad_count       = 0;
   int         samples_checked = 0;

   // ------------------------------------------------------------
   // clock, board and device
   // ------------------------------------------------------------
   always #25 clk = ~clk;

   pcc_strap_board BOARD (.code(code), .fitted(fitted), .pins(pins), .driven(driven));

   pcc_clock_ctrl #(.LOCK_CYCLES(LOCK)) DUT (
      .clk                     (clk),
      .arst_n                  (arst_n),
      .pll_ratio_select        (pins),
      .pll_ratio_select_driven (driven),
      .pll_ratio               (pll_ratio),
      .pll_mult_factor         (pll_mult_factor),
      .pll_enable              (pll_enable),
      .pll_bypass              (pll_bypass),
      .strap_reserved          (strap_reserved),
      .cpu_clock_valid         (cpu_clock_valid),
      .core_reset_n            (core_reset_n),
      .half_rate_clock_out     (divs[0]),
      .quarter_rate_clock_out  (divs[1]),
      .sixth_rate_clock_out    (divs[2]),
      .eighth_rate_clock_out   (divs[3])
   );

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   // sample point sits 5 ns after the edge so that edge's updates have landed
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask

   task automatic do_reset();
      arst_n = 1'b0;
      repeat (10) @(posedge clk);
      #5 arst_n = 1'b1;
   endtask

   // high and low spans of one divided clock, in reference cycles
   task automatic check_div(input int idx, input int n);
      int hi_n;
      int lo_n;
      hi_n = 0;
      lo_n = 0;
      // leave any high span already running, then start counting at a rising edge so the spans are whole
      for (int k = 0; k < 20 && divs[idx] === 1'b1; k++) step(1);
      for (int k = 0; k < 20 && divs[idx] !== 1'b1; k++) step(1);
      while (divs[idx] === 1'b1 && hi_n < 20) begin
         step(1);
         hi_n++;
      end
      while (divs[idx] === 1'b0 && lo_n < 20) begin
         step(1);
         lo_n++;
      end
      `CHK("div high cycles", n / 2, hi_n)
      `CHK("div low cycles", n / 2, lo_n)
   endtask

   // straps are flipped right after capture; the latched mode must not follow
   task automatic run_mode(input logic [1:0] c, input logic [1:0] f, input pcc_ratio_e r, input logic [3:0] m);
      logic lock;
      lock = (r == PCC_RATIO_X6) || (r == PCC_RATIO_X12);
      code = c;
      fitted = f;
      do_reset();
      step(3);
      `CHK("valid before capture", 1'b0, cpu_clock_valid)
      step(1);
      `CHK("ratio", r, pll_ratio)
      `CHK("factor", m, pll_mult_factor)
      `CHK("enable", lock, pll_enable)
      `CHK("bypass", !lock, pll_bypass)
      `CHK("reserved", (c & f) == 2'b11, strap_reserved)
      code = ~c;
      fitted = 2'b11;
      if (lock) begin
         step(LOCK - 1);
         `CHK("valid before lock", 1'b0, cpu_clock_valid)
         step(1);
      end
      `CHK("valid", 1'b1, cpu_clock_valid)
      `CHK("core reset held", 1'b0, core_reset_n)
      `CHK("divided clocks idle", 4'h0, divs)
      step(1);
      `CHK("core reset released", 1'b1, core_reset_n)
      `CHK("ratio kept", r, pll_ratio)
      for (int i = 0; i < 4; i++) check_div(i, 2 * (i + 1));
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_bypass();
      run_mode(2'b00, 2'b11, PCC_RATIO_BYPASS, 4'h1);
   endtask

   task automatic test_x6();
      run_mode(2'b01, 2'b11, PCC_RATIO_X6, 4'h6);
   endtask

   task automatic test_x12();
      run_mode(2'b10, 2'b11, PCC_RATIO_X12, 4'hC);
   endtask

   task automatic test_reserved();
      run_mode(2'b11, 2'b11, PCC_RATIO_RSVD, 4'h1);
   endtask

   // nothing fitted: pull-downs give bypass even with the board asking for 11
   task automatic test_unstrapped();
      run_mode(2'b11, 2'b00, PCC_RATIO_BYPASS, 4'h1);
   endtask

   // reset dropped in the middle of a lock wait, then a fresh start
   task automatic test_midrun_reset();
      code = 2'b01;
      fitted = 2'b11;
      do_reset();
      step(6);
      arst_n = 1'b0;
      #1;
      `CHK("factor in reset", 4'h1, pll_mult_factor)
      `CHK("bypass in reset", 1'b1, pll_bypass)
      `CHK("valid in reset", 1'b0, cpu_clock_valid)
      `CHK("core reset in reset", 1'b0, core_reset_n)
      run_mode(2'b10, 2'b11, PCC_RATIO_X12, 4'hC);
   endtask

   // ------------------------------------------------------------
   // verdict, watchdog and main sequence
   // ------------------------------------------------------------
   task automatic wrap_up();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // about 340 cycles are needed; a hang stops well past that
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      wrap_up();
   end

   initial begin
      test_bypass();
      test_x6();
      test_x12();
      test_reserved();
      test_unstrapped();
      test_midrun_reset();
      wrap_up();
   end
endmodule
